//--- dac_frontend_pkg.sv
package dac_frontend_pkg;

  // Register addresses
  localparam logic [4:0] REG_FORMAT_POWER = 5'h00;
  localparam logic [4:0] REG_FILTER_MUTE  = 5'h01;
  localparam logic [4:0] REG_ZERO_POL     = 5'h02;
  localparam logic [4:0] REG_VOLUME_LEFT  = 5'h03;
  localparam logic [4:0] REG_VOLUME_RIGHT = 5'h04;

  // Values after reset and writable-bit masks
  localparam logic [7:0] RST_FORMAT_POWER = 8'h8b;
  localparam logic [7:0] RST_FILTER_MUTE  = 8'h02;
  localparam logic [7:0] RST_ZERO_POL     = 8'h00;
  localparam logic [7:0] RST_VOLUME       = 8'hff;
  localparam logic [7:0] MASK_FORMAT_POWER = 8'h9f;
  localparam logic [7:0] MASK_ZERO_POL     = 8'h04;

  // Field positions
  localparam int BIT_TIMING_RESET = 0;
  localparam int BIT_POWER        = 1;
  localparam int FORMAT_LSB       = 2;
  localparam int BIT_AUTO_CLOCK   = 7;
  localparam int BIT_SOFT_MUTE    = 0;
  localparam int DEEMPH_LSB       = 1;
  localparam int SPEED_LSB        = 3;
  localparam int BIT_SLOW         = 5;
  localparam int BIT_ZERO_COMBINE = 6;
  localparam int BIT_ZERO_EN      = 7;
  localparam int BIT_ZERO_INVERT  = 2;

  // Control frame
  localparam logic [1:0] CHIP_ADDR       = 2'h1;
  localparam logic [4:0] CTRL_FRAME_BITS = 5'h10;

  // Speeds and de-emphasis codes
  localparam logic [1:0] SPEED_NORMAL = 2'h0;
  localparam logic [1:0] SPEED_DOUBLE = 2'h1;
  localparam logic [1:0] SPEED_QUAD   = 2'h2;
  localparam logic [1:0] DEEMPH_OFF   = 2'h1;

  // Frame counts
  localparam logic [4:0] STEP_FRAMES_NORMAL = 5'h04;
  localparam logic [4:0] STEP_FRAMES_DOUBLE = 5'h08;
  localparam logic [4:0] STEP_FRAMES_QUAD   = 5'h10;
  localparam logic [2:0] TRST_FALL_FRAMES   = 3'h4;
  localparam logic [2:0] TRST_RISE_FRAMES   = 3'h3;
  localparam int unsigned ZERO_RUN_DEFAULT  = 8192;

  typedef enum logic [2:0] {
    FMT_LSB16 = 3'b000,
    FMT_LSB20 = 3'b001,
    FMT_MSB24 = 3'b010,
    FMT_I2S24 = 3'b011,
    FMT_LSB24 = 3'b100
  } fmt_type;

  typedef enum logic [1:0] {
    PWR_DOWN     = 2'b00,
    PWR_WAIT_CLK = 2'b01,
    PWR_RUN      = 2'b10
  } pwr_state_type;

  typedef struct packed {
    logic        is_left;
    logic [23:0] data;
  } audio_sample_type;

  typedef struct packed {
    logic [1:0] chip_addr;
    logic       write_bit;
    logic [4:0] reg_addr;
    logic [7:0] value;
  } ctrl_frame_type;

endpackage : dac_frontend_pkg

//--- audio_serial_rx.sv
`timescale 1ns/1ns
module audio_serial_rx (
  input  logic                               clk_sys,
  input  logic                               srst,
  input  logic                               enable,
  input  logic                               bit_rise,
  input  logic                               frame_level,
  input  logic                               data_bit,
  input  dac_frontend_pkg::fmt_type          format_select,
  output dac_frontend_pkg::audio_sample_type sample,
  output logic                               sample_strobe
);
  import dac_frontend_pkg::*;

  logic [31:0] shift_reg;
  logic [5:0]  bit_cnt_reg;
  logic        frame_prev_reg;
  logic        primed_reg;
  logic [31:0] shift_next;
  logic [5:0]  cnt_next;
  logic        frame_edge;

  // I2S puts the left word in the low half of the frame clock
  function automatic logic left_of(input fmt_type f, input logic lvl);
    left_of = (f == FMT_I2S24) ? !lvl : lvl;
  endfunction : left_of

  assign shift_next = {shift_reg[30:0], data_bit};
  assign cnt_next   = (bit_cnt_reg == 6'h3f) ? bit_cnt_reg : 6'(bit_cnt_reg + 6'h01);
  assign frame_edge = frame_level != frame_prev_reg;

  always_ff @(posedge clk_sys) begin
    sample_strobe <= 1'b0;
    if (srst || !enable) begin
      shift_reg      <= 32'h0000_0000;
      bit_cnt_reg    <= 6'h00;
      frame_prev_reg <= 1'b0;
      primed_reg     <= 1'b0;
      sample         <= '0;
    end else if (bit_rise) begin
      shift_reg      <= shift_next;
      frame_prev_reg <= frame_level;
      if (frame_edge) begin
        bit_cnt_reg <= 6'h01;
        primed_reg  <= 1'b1;
        // Right-justified words end at the frame edge
        if (primed_reg && (format_select == FMT_LSB16 || format_select == FMT_LSB20 ||
                           format_select == FMT_LSB24)) begin
          sample_strobe  <= 1'b1;
          sample.is_left <= left_of(format_select, frame_prev_reg);
          if (format_select == FMT_LSB16) begin
            sample.data <= {shift_reg[15:0], 8'h00};
          end else if (format_select == FMT_LSB20) begin
            sample.data <= {shift_reg[19:0], 4'h0};
          end else begin
            sample.data <= shift_reg[23:0];
          end
        end
      end else begin
        bit_cnt_reg <= cnt_next;
        // Left-justified words end 24 or 25 bits in
        if (primed_reg && ((format_select == FMT_MSB24 && cnt_next == 6'h18) ||
                           (format_select == FMT_I2S24 && cnt_next == 6'h19))) begin
          sample_strobe  <= 1'b1;
          sample.is_left <= left_of(format_select, frame_level);
          sample.data    <= shift_next[23:0];
        end
      end
    end
  end

endmodule : audio_serial_rx

//--- stereo_dac_digital_frontend.sv
`timescale 1ns/1ns
module stereo_dac_digital_frontend #(
  parameter int unsigned ZERO_RUN_FRAMES = dac_frontend_pkg::ZERO_RUN_DEFAULT
) (
  input  logic        clk_sys,
  input  logic        srst,
  input  logic        powerdown_n,
  input  logic        mclk_present,
  input  logic [1:0]  detected_speed,
  input  logic        ctrl_select_n,
  input  logic        ctrl_clock,
  input  logic        ctrl_data_in,
  input  logic        bit_clock_in,
  input  logic        frame_clock_in,
  input  logic        serial_audio_in,
  output logic [23:0] audio_left_out,
  output logic [23:0] audio_right_out,
  output logic        audio_valid_out,
  output logic [1:0]  deemph_mode_out,
  output logic [1:0]  speed_mode_out,
  output logic        slow_rolloff_out,
  output logic        conversion_active_out,
  output logic        zero_flag_out_left,
  output logic        zero_flag_out_right
);
  import dac_frontend_pkg::*;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);

  logic [9:0]       sync1_reg;
  logic [9:0]       sync2_reg;
  logic [5:0]       prev_reg;
  logic             s_pd_n, s_mclk, s_cs_n, s_ctrl_clock, s_ctrl_data_in, s_bit_clock_in, s_frame_clock_in, s_serial_audio_in;
  logic [1:0]       s_speed;
  logic             ctrl_clock_rise, cs_rise, bit_clock_in_rise, frame_tick;
  logic [15:0]      ctrl_shift_reg;
  logic [4:0]       ctrl_cnt_reg;
  ctrl_frame_type   frame;
  logic             write_ok;
  logic [7:0]       control_format_power_reg;
  logic [7:0]       control_filter_mute_reg;
  logic [7:0]       control_zero_polarity_reg;
  logic [7:0]       volume_left_reg;
  logic [7:0]       volume_right_reg;
  logic             power_on, timing_reset_n_bit, soft_mute_en, zero_detect_en;
  logic             zero_flag_combine, zero_flag_invert;
  logic [1:0]       deemph_select, speed_sel, eff_speed;
  fmt_type          format_select;
  pwr_state_type    state_reg;
  logic             int_timing_reset_n_reg;
  logic [2:0]       trst_cnt_reg;
  logic [2:0]       trst_need;
  logic             active;
  logic [4:0]       step_cnt_reg;
  logic             step_tick_reg;
  logic [4:0]       step_frames;
  logic [7:0]       applied_reg [2];
  logic [7:0]       vol_w [2];
  logic [15:0]      zcnt_reg [2];
  logic [1:0]       zdet;
  logic             zero_both_l, zero_both_r;
  audio_sample_type rx_sample;
  logic             rx_strobe;

  // Two-flop synchronisers for every pin from outside this clock
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sync1_reg <= 10'h030;
      sync2_reg <= 10'h030;
      prev_reg  <= 6'h30;  // Idle select and control clock high: no false edge after reset
    end else begin
      sync1_reg <= {powerdown_n, mclk_present, detected_speed, ctrl_select_n, ctrl_clock,
                    ctrl_data_in, bit_clock_in, frame_clock_in, serial_audio_in};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg[5:0];
    end
  end

  assign s_pd_n  = sync2_reg[9];
  assign s_mclk  = sync2_reg[8];
  assign s_speed = sync2_reg[7:6];
  assign s_cs_n  = sync2_reg[5];
  assign s_ctrl_clock  = sync2_reg[4];
  assign s_ctrl_data_in  = sync2_reg[3];
  assign s_bit_clock_in  = sync2_reg[2];
  assign s_frame_clock_in  = sync2_reg[1];
  assign s_serial_audio_in  = sync2_reg[0];

  // Edge pulses on the synchronised copies
  assign ctrl_clock_rise  = s_ctrl_clock && !prev_reg[4];
  assign cs_rise    = s_cs_n && !prev_reg[5];
  assign bit_clock_in_rise  = s_bit_clock_in && !prev_reg[2];
  assign frame_tick = s_frame_clock_in && !prev_reg[1];

  // Control bits shift in on control-clock rise
  always_ff @(posedge clk_sys) begin
    if (srst || s_cs_n) begin
      ctrl_shift_reg <= 16'h0000;
      ctrl_cnt_reg   <= 5'h00;
    end else if (ctrl_clock_rise) begin
      ctrl_shift_reg <= {ctrl_shift_reg[14:0], s_ctrl_data_in};
      ctrl_cnt_reg   <= (ctrl_cnt_reg == 5'h1f) ? ctrl_cnt_reg : 5'(ctrl_cnt_reg + 5'h01);
    end
  end

  // Fixed chip address and write bit, exact length
  assign frame    = ctrl_frame_type'(ctrl_shift_reg);
  // No commit in power-down or without master clock
  assign write_ok = cs_rise && ctrl_cnt_reg == CTRL_FRAME_BITS && frame.chip_addr == CHIP_ADDR
                    && frame.write_bit && s_pd_n && s_mclk;

  // Short or foreign frames leave registers alone
  a_short_frame_drop: assert property (cs_rise && ctrl_cnt_reg != CTRL_FRAME_BITS && s_pd_n
    |=> $stable(volume_left_reg) && $stable(control_filter_mute_reg))
    else $error("register changed on malformed control frame");

  a_write_gated: assert property (s_pd_n && !s_mclk
    |=> $stable(control_format_power_reg) && $stable(volume_right_reg))
    else $error("register written without master clock");

  // Power-down restores defaults; writes taken whenever powered up with master clock
  always_ff @(posedge clk_sys) begin
    if (srst || !s_pd_n) begin
      control_format_power_reg  <= RST_FORMAT_POWER;
      control_filter_mute_reg   <= RST_FILTER_MUTE;
      control_zero_polarity_reg <= RST_ZERO_POL;
      volume_left_reg           <= RST_VOLUME;
      volume_right_reg          <= RST_VOLUME;
    end else if (write_ok) begin
      if (frame.reg_addr == REG_FORMAT_POWER) begin
        control_format_power_reg <= frame.value & MASK_FORMAT_POWER;
      end else if (frame.reg_addr == REG_FILTER_MUTE) begin
        control_filter_mute_reg <= frame.value;
      end else if (frame.reg_addr == REG_ZERO_POL) begin
        control_zero_polarity_reg <= frame.value & MASK_ZERO_POL;
      end else if (frame.reg_addr == REG_VOLUME_LEFT) begin
        volume_left_reg <= frame.value;
      end else if (frame.reg_addr == REG_VOLUME_RIGHT) begin
        volume_right_reg <= frame.value;
      end
    end
  end

  a_pd_regs_default: assert property (!s_pd_n
    |=> control_format_power_reg == RST_FORMAT_POWER && volume_left_reg == RST_VOLUME)
    else $error("registers not at defaults in power-down");

  // Field extraction
  assign timing_reset_n_bit          = control_format_power_reg[BIT_TIMING_RESET];
  assign power_on          = control_format_power_reg[BIT_POWER];
  assign format_select     = fmt_type'(control_format_power_reg[FORMAT_LSB +: 3]);
  assign soft_mute_en      = control_filter_mute_reg[BIT_SOFT_MUTE];
  assign deemph_select     = control_filter_mute_reg[DEEMPH_LSB +: 2];
  assign speed_sel         = control_filter_mute_reg[SPEED_LSB +: 2];
  assign zero_flag_combine = control_filter_mute_reg[BIT_ZERO_COMBINE];
  assign zero_detect_en    = control_filter_mute_reg[BIT_ZERO_EN];
  assign zero_flag_invert  = control_zero_polarity_reg[BIT_ZERO_INVERT];

  // Manual speed only when auto clock is off
  assign eff_speed = control_format_power_reg[BIT_AUTO_CLOCK] ? s_speed : speed_sel;

  // Wait for master clock and a frame edge before running
  always_ff @(posedge clk_sys) begin
    if (srst || !s_pd_n) begin
      state_reg <= PWR_DOWN;
    end else begin
      case (state_reg)
        PWR_DOWN:     state_reg <= PWR_WAIT_CLK;
        PWR_WAIT_CLK: if (s_mclk && frame_tick) begin
          state_reg <= PWR_RUN;
        end
        PWR_RUN:      if (!s_mclk) begin
          state_reg <= PWR_WAIT_CLK;
        end
        default:      state_reg <= PWR_DOWN;
      endcase
    end
  end

  // Internal timing reset follows the bit after whole frames
  assign trst_need = timing_reset_n_bit ? TRST_RISE_FRAMES : TRST_FALL_FRAMES;
  always_ff @(posedge clk_sys) begin
    if (srst || !s_pd_n || timing_reset_n_bit == int_timing_reset_n_reg) begin
      trst_cnt_reg <= 3'h0;
      if (srst || !s_pd_n) begin
        int_timing_reset_n_reg <= 1'b1;
      end
    end else if (frame_tick) begin
      if (3'(trst_cnt_reg + 3'h1) == trst_need) begin
        int_timing_reset_n_reg <= timing_reset_n_bit;
        trst_cnt_reg <= 3'h0;
      end else begin
        trst_cnt_reg <= 3'(trst_cnt_reg + 3'h1);
      end
    end
  end

  // Outside power-down the internal copy moves only on a frame edge
  a_trst_on_frame: assert property (s_pd_n && !frame_tick
    |=> int_timing_reset_n_reg == $past(int_timing_reset_n_reg))
    else $error("internal timing reset moved without a frame edge");

  // Power bit and timing reset stop the path, registers kept
  assign active = state_reg == PWR_RUN && int_timing_reset_n_reg && power_on;

  assign step_frames = (eff_speed == SPEED_QUAD) ? STEP_FRAMES_QUAD :
                       (eff_speed == SPEED_DOUBLE) ? STEP_FRAMES_DOUBLE : STEP_FRAMES_NORMAL;
  always_ff @(posedge clk_sys) begin
    step_tick_reg <= 1'b0;
    if (srst || !active) begin
      step_cnt_reg <= 5'h00;
    end else if (frame_tick) begin
      if (5'(step_cnt_reg + 5'h01) >= step_frames) begin
        step_cnt_reg  <= 5'h00;
        step_tick_reg <= 1'b1;
      end else begin
        step_cnt_reg <= 5'(step_cnt_reg + 5'h01);
      end
    end
  end

  assign vol_w[0] = volume_left_reg;
  assign vol_w[1] = volume_right_reg;

  // Per-channel level ramp and zero-run counter
  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [7:0] target;
    // Soft mute aims at zero; release turns back at once
    assign target = soft_mute_en ? 8'h00 : vol_w[ch];

    // One level per step toward the target
    always_ff @(posedge clk_sys) begin
      if (srst || !s_pd_n) begin
        applied_reg[ch] <= RST_VOLUME;
      end else if (step_tick_reg) begin
        if (applied_reg[ch] < target) begin
          applied_reg[ch] <= 8'(applied_reg[ch] + 8'h01);
        end else if (applied_reg[ch] > target) begin
          applied_reg[ch] <= 8'(applied_reg[ch] - 8'h01);
        end
      end
    end

    // Count consecutive zero samples, restart on nonzero
    always_ff @(posedge clk_sys) begin
      if (srst || !active) begin
        zcnt_reg[ch] <= 16'h0000;
      end else if (rx_strobe && (rx_sample.is_left == (ch == 0))) begin
        if (rx_sample.data != 24'h000000) begin
          zcnt_reg[ch] <= 16'h0000;
        end else if (zcnt_reg[ch] < 16'(ZERO_RUN_FRAMES)) begin
          zcnt_reg[ch] <= 16'(zcnt_reg[ch] + 16'h0001);
        end
      end
    end
    assign zdet[ch] = zcnt_reg[ch] >= 16'(ZERO_RUN_FRAMES);
  end

  // Outside power-down, levels move by one and only on a step
  a_vol_step_one: assert property ($changed(applied_reg[0]) && $past(s_pd_n)
    |-> $past(step_tick_reg) && (applied_reg[0] == 8'($past(applied_reg[0]) + 8'h01)
        || applied_reg[0] == 8'($past(applied_reg[0]) - 8'h01)))
    else $error("volume level jumped or moved off step");

  // Muting descends one level per step
  a_mute_ramp_down: assert property (s_pd_n && step_tick_reg && soft_mute_en
    && applied_reg[1] != 8'h00 |=> applied_reg[1] == 8'($past(applied_reg[1]) - 8'h01))
    else $error("soft mute did not descend");

  // Released mute climbs back toward the volume
  a_mute_release_up: assert property (s_pd_n && step_tick_reg && !soft_mute_en
    && applied_reg[0] < volume_left_reg |=> applied_reg[0] == 8'($past(applied_reg[0]) + 8'h01))
    else $error("level did not climb after mute release");

  // Combined mode needs both channels in a run
  assign zero_both_l = zero_flag_combine ? (zdet[0] && zdet[1]) : zdet[0];
  assign zero_both_r = zero_flag_combine ? (zdet[0] && zdet[1]) : zdet[1];

  always_ff @(posedge clk_sys) begin
    if (srst || !s_pd_n || !zero_detect_en) begin
      zero_flag_out_left  <= 1'b0;
      zero_flag_out_right <= 1'b0;
    end else if (!int_timing_reset_n_reg) begin
      zero_flag_out_left  <= 1'b1;
      zero_flag_out_right <= 1'b1;
    end else begin
      zero_flag_out_left  <= zero_both_l ^ zero_flag_invert;
      zero_flag_out_right <= zero_both_r ^ zero_flag_invert;
    end
  end

  a_pd_flags_low: assert property (!s_pd_n
    |=> !zero_flag_out_left && !zero_flag_out_right)
    else $error("zero flag high in power-down");

  a_zero_disabled: assert property (s_pd_n && !zero_detect_en
    |=> !zero_flag_out_left && !zero_flag_out_right)
    else $error("zero flag high while detection disabled");

  a_trst_flags_high: assert property (s_pd_n && zero_detect_en && !int_timing_reset_n_reg
    |=> zero_flag_out_left && zero_flag_out_right)
    else $error("zero flags not high during timing reset");

  sequence seq_left_nonzero;
    rx_strobe && rx_sample.is_left && rx_sample.data != 24'h000000;
  endsequence
  sequence seq_flags_live;
    s_pd_n && zero_detect_en && int_timing_reset_n_reg && !zero_flag_combine;
  endsequence

  // Nonzero sample drops the flag at once
  a_zero_release: assert property (seq_left_nonzero ##1 seq_flags_live
    |=> zero_flag_out_left == zero_flag_invert)
    else $error("zero flag did not drop after nonzero sample");

  // Serial capture in the selected format
  audio_serial_rx u_rx (
    .clk_sys       (clk_sys),
    .srst          (srst),
    .enable        (active),
    .bit_rise      (bit_clock_in_rise),
    .frame_level   (s_frame_clock_in),
    .data_bit      (s_serial_audio_in),
    .format_select (format_select),
    .sample        (rx_sample),
    .sample_strobe (rx_strobe)
  );

  // Linear gain; full scale passes untouched
  function automatic logic [23:0] scale_sample(input logic [23:0] s, input logic [7:0] lvl);
    logic signed [32:0] prod;
    prod = $signed(s) * $signed({1'b0, lvl});
    scale_sample = (lvl == 8'hff) ? s : prod[31:8];
  endfunction : scale_sample

  // Scaled samples out; a right word closes the frame
  always_ff @(posedge clk_sys) begin
    audio_valid_out <= 1'b0;
    if (srst || !active) begin
      audio_left_out  <= 24'h000000;
      audio_right_out <= 24'h000000;
    end else if (rx_strobe) begin
      if (rx_sample.is_left) begin
        audio_left_out <= scale_sample(rx_sample.data, applied_reg[0]);
      end else begin
        audio_right_out <= scale_sample(rx_sample.data, applied_reg[1]);
        audio_valid_out <= 1'b1;
      end
    end
  end

  // De-emphasis choice, forced off above normal speed
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      deemph_mode_out       <= DEEMPH_OFF;
      speed_mode_out        <= SPEED_NORMAL;
      slow_rolloff_out      <= 1'b0;
      conversion_active_out <= 1'b0;
    end else begin
      deemph_mode_out       <= (eff_speed == SPEED_NORMAL) ? deemph_select : DEEMPH_OFF;
      speed_mode_out        <= eff_speed;
      slow_rolloff_out      <= control_filter_mute_reg[BIT_SLOW];
      conversion_active_out <= active;
    end
  end

  // Bypass at double and quad speed
  a_deemph_bypass: assert property (eff_speed != SPEED_NORMAL
    |=> deemph_mode_out == DEEMPH_OFF)
    else $error("de-emphasis active above normal speed");

endmodule : stereo_dac_digital_frontend

//--- audio_src_model.sv
`timescale 1ns/1ns
module audio_src_model (
  input  wire logic [23:0] left_w,
  input  wire logic [23:0] right_w,
  input  wire logic [2:0]  fmt,
  output logic             bclk,
  output logic             fclk,
  output logic             sdat
);
  logic [5:0]  pos = 6'h3f;
  logic [23:0] w;
  int          idx;
  // Start levels, so the pins are never unknown
  initial begin
    bclk = 1'b0;
    fclk = 1'b0;
    sdat = 1'b0;
  end
  // Link clock runs free: audio clocks stay present in normal operation
  always #80 bclk = ~bclk;
  // Change on the fall, MSB first, 64 bits a frame
  always @(negedge bclk) begin
    pos = pos + 6'h1;
    fclk = (fmt == 3'h3) ? pos[5] : ~pos[5];
    w = pos[5] ? right_w : left_w;
    // MSB slot: 0 left-justified, 1 for I2S, 32 minus the width when right-justified
    case (fmt)
      3'h0:    idx = 39 - int'(pos[4:0]);
      3'h1:    idx = 35 - int'(pos[4:0]);
      3'h3:    idx = 24 - int'(pos[4:0]);
      3'h4:    idx = 31 - int'(pos[4:0]);
      default: idx = 23 - int'(pos[4:0]);
    endcase
    // Idle slots toggle, so stale bits never pass for data
    sdat = (idx >= 0 && idx < 24) ? w[idx] : ~sdat;
  end
endmodule : audio_src_model

//--- stereo_dac_digital_frontend_test.sv
`timescale 1ns/1ns
module stereo_dac_digital_frontend_test;
  import dac_frontend_pkg::*;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic powerdown_n = 1'b1;
  logic mclk_present = 1'b1;
  logic ctrl_select_n = 1'b1;
  logic ctrl_clock = 1'b1;
  logic ctrl_data_in = 1'b0;
  logic bclk, fclk, sdat, valid, act;
  logic [23:0] left_w = 24'h0, right_w = 24'h0, lout, rout;
  logic [1:0] dem, spd, zf;
  logic [1:0] det_spd = SPEED_NORMAL;
  logic [2:0] fmt = 3'h2;
  int n_mismatch = 0, compares = 0, seed = 61;
  // Clock
  always #10 clk_sys = ~clk_sys;
  audio_src_model i_src (.left_w, .right_w, .fmt, .bclk, .fclk, .sdat);
  stereo_dac_digital_frontend #(.ZERO_RUN_FRAMES(16)) i_dut (
    .clk_sys, .srst, .powerdown_n, .mclk_present, .detected_speed(det_spd),
    .ctrl_select_n, .ctrl_clock, .ctrl_data_in, .bit_clock_in(bclk),
    .frame_clock_in(fclk), .serial_audio_in(sdat), .audio_left_out(lout),
    .audio_right_out(rout), .audio_valid_out(valid), .deemph_mode_out(dem),
    .speed_mode_out(spd), .slow_rolloff_out(), .conversion_active_out(act),
    .zero_flag_out_left(zf[1]), .zero_flag_out_right(zf[0]));
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : tick
  task automatic frames(input int n);
    tick(512 * n);
  endtask : frames
  // Data changes with the clock low and holds across the rise
  task automatic send(input logic [15:0] w, input int nb);
    ctrl_select_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      ctrl_clock = 1'b0;
      ctrl_data_in = w[15 - i];
      tick(5);
      ctrl_clock = 1'b1;
      tick(5);
    end
    ctrl_select_n = 1'b1;
    tick(10);
  endtask : send
  // Only addresses 00h to 04h are ever written
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    send({CHIP_ADDR, 1'b1, a, v}, 16);
  endtask : wr
  task automatic wait_valid;
    int k;
    for (k = 0; k < 700 && valid !== 1'b1; k++)
      tick(1);
    if (k == 700) begin
      check(24'h0, 24'h1);
      wrap_up();
    end
  endtask : wait_valid
  // Expected level: 255 passes exactly, else sample times level, shifted
  function automatic logic [23:0] scaled(input logic [23:0] s, input logic [7:0] v);
    logic signed [32:0] p;
    p = $signed(s) * $signed({1'b0, v});
    return (v == 8'hff) ? s : p[31:8];
  endfunction : scaled
  // Expected capture: short right-justified words arrive left-aligned in 24 bits
  function automatic logic [23:0] word_in(input logic [23:0] w, input logic [2:0] f);
    if (f == FMT_LSB16) return {w[23:8], 8'h00};
    if (f == FMT_LSB20) return {w[23:4], 4'h0};
    return w;
  endfunction : word_in
  // Main sequence
  initial begin
    tick(10);
    srst = 1'b0;
    frames(4);
    check({dem, act}, 3'b011);
    // Every format once, ending on the default left-justified one
    for (int t = 0; t < 5; t++) begin
      fmt = 3'((t + 3) % 5);
      wr(REG_FORMAT_POWER, {1'b1, 2'b00, fmt, 2'b11});
      left_w = 24'($random(seed));
      right_w = 24'($random(seed));
      tick(1100);
      wait_valid();
      check(lout, word_in(left_w, fmt));
      check(rout, word_in(right_w, fmt));
    end
    send({2'h2, 1'b1, REG_VOLUME_LEFT, 8'h00}, 16);
    send({CHIP_ADDR, 1'b0, REG_VOLUME_LEFT, 8'h00}, 16);
    send({CHIP_ADDR, 1'b1, REG_VOLUME_LEFT, 8'h00}, 15);
    mclk_present = 1'b0;
    tick(5);
    wr(REG_VOLUME_LEFT, 8'h00);
    mclk_present = 1'b1;
    frames(6);
    wait_valid();
    check(lout, left_w);
    $display("test stream and refused writes done");
    wr(REG_VOLUME_LEFT, 8'hfb);
    frames(2);
    wait_valid();
    check(lout == scaled(left_w, 8'hfb), 1'b0);
    frames(20);
    wait_valid();
    check(lout, scaled(left_w, 8'hfb));
    check(rout, right_w);
    wr(REG_FORMAT_POWER, 8'h89);
    check(act, 1'b0);
    wr(REG_FORMAT_POWER, 8'h8b);
    check(act, 1'b1);
    wr(REG_FILTER_MUTE, 8'h03);
    frames(9);
    wait_valid();
    check(lout == scaled(left_w, 8'hfb), 1'b0);
    check(rout == right_w, 1'b0);
    wr(REG_FILTER_MUTE, 8'h02);
    frames(20);
    wait_valid();
    check(lout, scaled(left_w, 8'hfb));
    check(rout, right_w);
    $display("test volume done");
    wr(REG_FORMAT_POWER, 8'h0b);
    for (int sp = 0; sp < 3; sp++) begin
      for (int dm = 0; dm < 4; dm++) begin
        wr(REG_FILTER_MUTE, {3'h0, sp[1:0], dm[1:0], 1'b0});
        check(dem, sp == 0 ? dm[1:0] : DEEMPH_OFF);
        check(spd, sp[1:0]);
      end
    end
    wr(REG_FORMAT_POWER, 8'h8b);
    check(spd, SPEED_NORMAL);
    det_spd = SPEED_DOUBLE;
    tick(5);
    check({spd, dem}, {SPEED_DOUBLE, DEEMPH_OFF});
    det_spd = SPEED_NORMAL;
    tick(5);
    $display("test modes done");
    wr(REG_FILTER_MUTE, 8'h82);
    left_w = 24'h0;
    right_w = 24'h000123;
    frames(20);
    check(zf, 2'b10);
    wr(REG_ZERO_POL, 8'h04);
    check(zf, 2'b01);
    wr(REG_ZERO_POL, 8'h00);
    wr(REG_FILTER_MUTE, 8'hc2);
    check(zf, 2'b00);
    wr(REG_FILTER_MUTE, 8'h02);
    check(zf, 2'b00);
    wr(REG_FILTER_MUTE, 8'h82);
    left_w = 24'h000001;
    frames(2);
    check(zf, 2'b00);
    wr(REG_FORMAT_POWER, 8'h8a);
    frames(2);
    check({zf, act}, 3'b001);
    frames(3);
    check({zf, act}, 3'b110);
    wr(REG_FORMAT_POWER, 8'h8b);
    frames(1);
    check(zf, 2'b11);
    frames(3);
    check({zf, act}, 3'b001);
    $display("test zero flags and timing reset done");
    wr(REG_FILTER_MUTE, 8'h84);
    wr(REG_ZERO_POL, 8'h04);
    check({dem, zf}, 4'b1011);
    powerdown_n = 1'b0;
    tick(10);
    check({dem, zf}, 4'b0100);
    wr(REG_FILTER_MUTE, 8'h84);
    powerdown_n = 1'b1;
    frames(3);
    check({dem, zf, act}, 5'b01001);
    $display("test power-down done");
    wrap_up();
  end
endmodule : stereo_dac_digital_frontend_test
